// ---- design/qec_pkg.sv ----
// package for the quadrature encoder counter: register map, field positions,
// reset values and shared state types.
// assumes a single 100 MHz system clock and a 7-bit word register address.
package qec_pkg;

  // register port geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;

  // register word addresses
  localparam logic [6:0] ADDR_CONFIG = 7'h38;
  localparam logic [6:0] ADDR_POSITION = 7'h39;
  localparam logic [6:0] ADDR_SCALE = 7'h3A;
  localparam logic [6:0] ADDR_FLAGS = 7'h3B;
  localparam logic [6:0] ADDR_CAPTURE = 7'h3C;
  localparam logic [6:0] ADDR_SLIP_LIMIT = 7'h3D;
  localparam logic [6:0] ADDR_RAMP_CAPTURE = 7'h3E;

  // field widths
  localparam int CFG_W = 11;
  localparam int LIMIT_W = 20;
  localparam int FRAC_W = 16;

  // encoder_config bit positions
  localparam int CFG_DECIMAL = 10;
  localparam int CFG_LATCH_RAMP = 9;
  localparam int CFG_CLEAR_POS = 8;
  localparam int CFG_NEG_EDGE = 7;
  localparam int CFG_POS_EDGE = 6;
  localparam int CFG_ONCE = 5;
  localparam int CFG_CONT = 4;
  localparam int CFG_SKIP_AB = 3;
  localparam int CFG_POL_N = 2;
  localparam int CFG_POL_B = 1;
  localparam int CFG_POL_A = 0;

  // encoder_event_flags bit positions
  localparam int FLAG_INDEX = 0;
  localparam int FLAG_DEV = 1;

  // reset values and arithmetic constants
  localparam logic [31:0] SCALE_RESET = 32'h0001_0000;
  localparam logic [16:0] DEC_BASE = 17'h0_2710;
  localparam int SYNC_STAGES = 2;

  // index sensitivity encodings, {neg_edge, pos_edge}
  typedef enum logic [1:0] {
    QEC_IDX_LEVEL = 2'b00,
    QEC_IDX_RISE = 2'b01,
    QEC_IDX_FALL = 2'b10,
    QEC_IDX_BOTH = 2'b11
  } qec_idx_mode_t;

  // decoder state
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [1:0] prev_ab;
    logic step;
    logic up;
  } qec_dec_state_t;

  // core state
  typedef struct packed {
    logic [10:0] config_bits;
    logic [31:0] position;
    logic [15:0] frac;
    logic [31:0] scale;
    logic [1:0] flags;
    logic [31:0] capture;
    logic [31:0] ramp_capture;
    logic [19:0] slip_limit;
    logic once_armed;
    logic q_prev;
    logic [31:0] rdata;
    logic irq;
  } qec_core_state_t;

endpackage

// ---- design/qec_dec_if.sv ----
// interface carrying decoded encoder levels and count strobes from the
// decoder to the counter core; both ends on the same clock.
`timescale 1ns/1ps
interface qec_dec_if;
  logic a_lvl;
  logic b_lvl;
  logic n_lvl;
  logic step;
  logic up;

  modport dec (output a_lvl, output b_lvl, output n_lvl, output step, output up);
  modport core (input a_lvl, input b_lvl, input n_lvl, input step, input up);
endinterface // qec_dec_if

// ---- design/qec_quad_decoder.sv ----
// quadrature decoder: synchronises A, B and N pins and produces one count
// strobe per valid gray step. assumes pins are asynchronous to clk.
`timescale 1ns/1ps
module qec_quad_decoder #(
  parameter int STAGES = qec_pkg::SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_n,
  qec_dec_if.dec dec
);

  initial begin
    if (STAGES != 2) begin
      $error("qec_quad_decoder: only two sync stages supported");
    end
  end

  qec_pkg::qec_dec_state_t st_reg;
  qec_pkg::qec_dec_state_t st_next;
  logic [3:0] trans;

  // sync pins, then classify the transition of the synced A/B pair
  always_comb begin
    st_next = st_reg;
    st_next.s1 = {pin_n, pin_b, pin_a};
    st_next.s2 = st_reg.s1;
    st_next.prev_ab = st_reg.s2[1:0];
    trans = {st_reg.prev_ab, st_reg.s2[1:0]};
    st_next.step = 1'b0;
    st_next.up = st_reg.up;
    // {b,a}: 00 -> 01 -> 11 -> 10 counts up, reverse counts down
    unique case (trans)
      4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
        st_next.step = 1'b1;
        st_next.up = 1'b1;
      end
      4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
        st_next.step = 1'b1;
        st_next.up = 1'b0;
      end
      default: begin
        st_next.step = 1'b0; // no change or double transition ignored
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dec.a_lvl = st_reg.s2[0];
  assign dec.b_lvl = st_reg.s2[1];
  assign dec.n_lvl = st_reg.s2[2];
  assign dec.step = st_reg.step;
  assign dec.up = st_reg.up;

  double_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.prev_ab ^ st_reg.s2[1:0]) == 2'b11 |=> !st_reg.step)
    else $error("double transition produced a count");

endmodule // qec_quad_decoder

// ---- design/qec_counter.sv ----
// quadrature encoder counter: scaled position accumulator, index capture and
// clear, deviation monitor and register port.
// assumes ramp position and step/dir mode come from logic on the same clock.
`timescale 1ns/1ps

// Summary of operation
// - encoder counting and index events stop while step/dir input mode is on.
// - position is a signed 32-bit counter, readable and writable by software.
// - scale factor is signed 16.16 fixed point, resetting to one.
// - each count adds or subtracts scale; config bit 10 picks decimal fraction.
// - in decimal mode the fraction counts ten-thousandths.
// - flag bit 0 is index event, bit 1 deviation; writing one clears.
// - deviation flag cannot be cleared while deviation still exists.
// - either flag set drives the interrupt output.
// - capture register takes the position on each qualifying index event enabled by config bit 4 or 5.
// - nonzero 20-bit limit flags deviation when encoder and ramp differ more.
// - config bit 9 also captures ramp position on the index event.
// - config bit 8 zeroes the position after capturing it.
// - bits 7:6 pick level, active edge, inactive edge or both edges.
// - config bit 5 acts only on the first index event after the write.
// - config bit 4 acts on every qualifying index event.
// - bit 3 clear requires A and B polarity match; set ignores them.
// - config bit 2 sets index active level, one meaning high.
// - config bits 0 and 1 give required A and B levels.
module qec_counter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  input wire logic step_dir_mode,
  input wire logic [31:0] ramp_current_position,
  output logic irq
);

  // reset release through two flops
  logic rst_s1_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  qec_dec_if dec_bus ();

  qec_quad_decoder #(
    .STAGES(qec_pkg::SYNC_STAGES)
  ) u_dec (
    .clk(clk),
    .rst_n(rst_n),
    .pin_a(enc_a),
    .pin_b(enc_b),
    .pin_n(enc_n),
    .dec(dec_bus)
  );

  qec_pkg::qec_core_state_t st_reg;
  qec_pkg::qec_core_state_t st_next;

  logic enc_active;
  logic count_en;
  logic idx_level;
  logic ab_match;
  logic idx_q;
  logic idx_evt;
  logic evt_fire;
  logic dev_cond;
  logic [32:0] diff;
  logic [32:0] diff_abs;
  logic [47:0] bin_sum;
  logic [47:0] scale_ext;
  logic [16:0] dec_t;
  logic dec_carry;
  logic [31:0] dec_int;
  logic [15:0] dec_frac;
  logic [31:0] cnt_pos;
  logic [15:0] cnt_frac;
  logic wr_config;
  logic wr_position;
  logic wr_flags;
  logic [1:0] flag_set;
  logic [31:0] rd_mux;

  // encoder logic sleeps in step/dir mode
  assign enc_active = !step_dir_mode;
  assign count_en = enc_active && dec_bus.step;

  // index qualification from synced N, A and B levels
  assign idx_level = dec_bus.n_lvl == st_reg.config_bits[qec_pkg::CFG_POL_N];
  assign ab_match = st_reg.config_bits[qec_pkg::CFG_SKIP_AB] ||
    ((dec_bus.a_lvl == st_reg.config_bits[qec_pkg::CFG_POL_A]) &&
     (dec_bus.b_lvl == st_reg.config_bits[qec_pkg::CFG_POL_B]));
  assign idx_q = idx_level && ab_match;

  // sensitivity select on the qualified index level
  always_comb begin
    unique case (qec_pkg::qec_idx_mode_t'(st_reg.config_bits[7:6]))
      qec_pkg::QEC_IDX_LEVEL: idx_evt = idx_q;
      qec_pkg::QEC_IDX_RISE: idx_evt = idx_q && !st_reg.q_prev;
      qec_pkg::QEC_IDX_FALL: idx_evt = !idx_q && st_reg.q_prev;
      qec_pkg::QEC_IDX_BOTH: idx_evt = idx_q ^ st_reg.q_prev;
    endcase
  end

  // capture fires continuously or once after arming
  assign evt_fire = enc_active && idx_evt &&
    (st_reg.config_bits[qec_pkg::CFG_CONT] || st_reg.once_armed);

  // deviation between encoder count and ramp position
  assign diff = {st_reg.position[31], st_reg.position} -
    {ramp_current_position[31], ramp_current_position};
  assign diff_abs = diff[32] ? 33'(-diff) : diff;
  assign dev_cond = (st_reg.slip_limit != 20'h0_0000) &&
    (diff_abs > {13'h0000, st_reg.slip_limit});

  // binary accumulate: 32.16 position plus or minus sign-extended 16.16 scale
  assign scale_ext = {{16{st_reg.scale[31]}}, st_reg.scale};
  assign bin_sum = dec_bus.up ? {st_reg.position, st_reg.frac} + scale_ext
                              : {st_reg.position, st_reg.frac} - scale_ext;

  // decimal accumulate: fraction in ten-thousandths with carry or borrow
  assign dec_int = {{16{st_reg.scale[31]}}, st_reg.scale[31:16]};
  always_comb begin
    dec_t = 17'h0_0000;
    dec_carry = 1'b0;
    dec_frac = st_reg.frac;
    if (dec_bus.up) begin
      dec_t = {1'b0, st_reg.frac} + {1'b0, st_reg.scale[15:0]};
      dec_carry = dec_t >= qec_pkg::DEC_BASE;
      dec_frac = dec_carry ? 16'(dec_t - qec_pkg::DEC_BASE) : dec_t[15:0];
    end else begin
      dec_t = {1'b0, st_reg.frac} - {1'b0, st_reg.scale[15:0]};
      dec_carry = dec_t[16];
      dec_frac = dec_carry ? 16'(dec_t + qec_pkg::DEC_BASE) : dec_t[15:0];
    end
  end

  // pick the count result for the selected fraction base
  always_comb begin
    if (st_reg.config_bits[qec_pkg::CFG_DECIMAL]) begin
      cnt_frac = dec_frac;
      if (dec_bus.up) begin
        cnt_pos = st_reg.position + dec_int + {31'h0000_0000, dec_carry};
      end else begin
        cnt_pos = st_reg.position - dec_int - {31'h0000_0000, dec_carry};
      end
    end else begin
      cnt_pos = bin_sum[47:16];
      cnt_frac = bin_sum[15:0];
    end
  end

  // register write decodes
  assign wr_config = reg_wr && (reg_addr == qec_pkg::ADDR_CONFIG);
  assign wr_position = reg_wr && (reg_addr == qec_pkg::ADDR_POSITION);
  assign wr_flags = reg_wr && (reg_addr == qec_pkg::ADDR_FLAGS);

  // hardware flag sources
  assign flag_set[qec_pkg::FLAG_INDEX] = enc_active && idx_evt;
  assign flag_set[qec_pkg::FLAG_DEV] = dev_cond;

  // read mux; write-only registers read as zero
  always_comb begin
    unique case (reg_addr)
      qec_pkg::ADDR_CONFIG: rd_mux = {21'h00_0000, st_reg.config_bits};
      qec_pkg::ADDR_POSITION: rd_mux = st_reg.position;
      qec_pkg::ADDR_FLAGS: rd_mux = {30'h0000_0000, st_reg.flags};
      qec_pkg::ADDR_CAPTURE: rd_mux = st_reg.capture;
      qec_pkg::ADDR_RAMP_CAPTURE: rd_mux = st_reg.ramp_capture;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    st_next = st_reg;
    st_next.q_prev = idx_q;
    // scaled counting
    if (count_en) begin
      st_next.position = cnt_pos;
      st_next.frac = cnt_frac;
    end
    // index action: capture, optional ramp capture and clear
    if (evt_fire) begin
      st_next.capture = st_reg.position;
      if (st_reg.config_bits[qec_pkg::CFG_LATCH_RAMP]) begin
        st_next.ramp_capture = ramp_current_position;
      end
      if (st_reg.config_bits[qec_pkg::CFG_CLEAR_POS]) begin
        st_next.position = 32'h0000_0000;
        st_next.frac = 16'h0000;
      end
      st_next.once_armed = 1'b0;
    end
    // software writes take priority over counting
    if (wr_config) begin
      st_next.config_bits = reg_wdata[10:0];
      st_next.once_armed = reg_wdata[qec_pkg::CFG_ONCE];
    end
    if (wr_position) begin
      st_next.position = reg_wdata;
      st_next.frac = 16'h0000;
    end
    if (reg_wr && (reg_addr == qec_pkg::ADDR_SCALE)) begin
      st_next.scale = reg_wdata;
    end
    if (reg_wr && (reg_addr == qec_pkg::ADDR_SLIP_LIMIT)) begin
      st_next.slip_limit = reg_wdata[19:0];
    end
    // write-one clear, set wins; deviation holds while present
    if (wr_flags) begin
      st_next.flags = (st_reg.flags & ~reg_wdata[1:0]) | flag_set;
    end else begin
      st_next.flags = st_reg.flags | flag_set;
    end
    st_next.irq = |st_next.flags;
    st_next.rdata = reg_rd ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.scale <= qec_pkg::SCALE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign irq = st_reg.irq;

  // checks

  irq_follows_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.flags != 2'b00 && !wr_flags |-> irq)
    else $error("interrupt low while a flag is set");

  capture_on_index_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt_fire |=> st_reg.capture == $past(st_reg.position))
    else $error("capture missed position on index event");

  ramp_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt_fire && st_reg.config_bits[9] |=> st_reg.ramp_capture == $past(ramp_current_position))
    else $error("ramp position not captured");

  index_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt_fire && st_reg.config_bits[8] && !wr_position |=> st_reg.position == 32'h0000_0000)
    else $error("position not cleared on index event");

  once_disarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt_fire && !wr_config ##1 !st_reg.config_bits[4] && idx_evt && !wr_config
      |-> !evt_fire)
    else $error("single-shot capture fired twice");

  stepdir_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    step_dir_mode && !wr_position |=> $stable(st_reg.position) && !$rose(st_reg.flags[0]))
    else $error("encoder active in step/dir mode");

  dev_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    dev_cond |=> st_reg.flags[1] && irq)
    else $error("deviation flag cleared while deviation present");

  binary_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    count_en && dec_bus.up && !st_reg.config_bits[10] && !evt_fire && !wr_position
      |=> {st_reg.position, st_reg.frac} ==
          $past({st_reg.position, st_reg.frac}) + $past(scale_ext))
    else $error("binary accumulate wrong");

  rise_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.config_bits[7:6] == 2'b01 && idx_evt |-> idx_q && !st_reg.q_prev)
    else $error("rising sensitivity fired without a rising edge");

  flags_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == qec_pkg::ADDR_FLAGS
      |=> reg_rdata == {30'h0000_0000, $past(st_reg.flags)})
    else $error("flag read data wrong");

  // index qualification, sensitivity, capture and clear checks

  level_event_a: assert property (@(posedge clk) disable iff (!rst_n)
    enc_active && st_reg.config_bits[7:6] == 2'b00 && idx_q
      |=> st_reg.flags[qec_pkg::FLAG_INDEX])
    else $error("level sensitivity missed an index");

  fall_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    enc_active && st_reg.config_bits[7:6] == 2'b10 && !idx_q && st_reg.q_prev
      |=> st_reg.flags[qec_pkg::FLAG_INDEX])
    else $error("falling sensitivity missed an index");

  pol_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    dec_bus.n_lvl != st_reg.config_bits[qec_pkg::CFG_POL_N] && !st_reg.q_prev |-> !idx_evt)
    else $error("index event at the inactive level");

  ab_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    !st_reg.config_bits[qec_pkg::CFG_SKIP_AB] && !st_reg.q_prev &&
    (dec_bus.a_lvl != st_reg.config_bits[qec_pkg::CFG_POL_A] ||
     dec_bus.b_lvl != st_reg.config_bits[qec_pkg::CFG_POL_B]) |-> !idx_evt)
    else $error("index event with a/b mismatch");

  skip_ab_a: assert property (@(posedge clk) disable iff (!rst_n)
    enc_active && st_reg.config_bits[qec_pkg::CFG_SKIP_AB] && idx_level &&
    st_reg.config_bits[7:6] == 2'b00 |=> st_reg.flags[qec_pkg::FLAG_INDEX])
    else $error("a/b levels not ignored");

  cont_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    enc_active && idx_evt && st_reg.config_bits[qec_pkg::CFG_CONT]
      |=> st_reg.capture == $past(st_reg.position))
    else $error("continuous mode skipped an index");

  no_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt_fire && !st_reg.config_bits[qec_pkg::CFG_CLEAR_POS] && !count_en && !wr_position
      |=> $stable(st_reg.position))
    else $error("position cleared with clear off");

  // register write, arithmetic and deviation checks

  pos_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_position |=> st_reg.position == $past(reg_wdata))
    else $error("position write lost");

  scale_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == qec_pkg::ADDR_SCALE |=> st_reg.scale == $past(reg_wdata))
    else $error("scale write lost");

  dec_frac_a: assert property (@(posedge clk) disable iff (!rst_n)
    count_en && st_reg.config_bits[qec_pkg::CFG_DECIMAL] && !evt_fire && !wr_position &&
    {1'b0, st_reg.frac} < qec_pkg::DEC_BASE && {1'b0, st_reg.scale[15:0]} < qec_pkg::DEC_BASE
      |=> {1'b0, st_reg.frac} < qec_pkg::DEC_BASE)
    else $error("decimal fraction out of range");

  limit_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.slip_limit == 20'h0_0000 && !st_reg.flags[qec_pkg::FLAG_DEV]
      |=> !st_reg.flags[qec_pkg::FLAG_DEV])
    else $error("deviation flagged with check off");

  dev_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_flags && reg_wdata[qec_pkg::FLAG_DEV] && !dev_cond |=> !st_reg.flags[qec_pkg::FLAG_DEV])
    else $error("deviation flag not cleared");

endmodule // qec_counter

// ---- testbench/qec_enc_model.sv ----
// partner model: incremental A/B encoder with an index line.
// assumes the bench asks for at most one move or jump every two cycles.
`timescale 1ns/1ps
module qec_enc_model (
  input wire logic clk,
  input wire logic move,
  input wire logic dir_up,
  input wire logic jump,
  input wire logic index_lvl,
  output logic enc_a,
  output logic enc_b,
  output logic enc_n
);
  logic [1:0] phase_reg = 2'h0;

  // one gray step per move; a jump flips both lines at once
  always @(posedge clk) begin
    if (move) begin
      phase_reg <= dir_up ? phase_reg + 2'h1 : phase_reg - 2'h1;
    end else if (jump) begin
      phase_reg <= phase_reg + 2'h2;
    end
  end

  // phase to {b,a}: 00, 01, 11, 10 counting up
  assign enc_a = phase_reg[0] ^ phase_reg[1];
  assign enc_b = phase_reg[1];
  assign enc_n = index_lvl;
endmodule // qec_enc_model

// ---- testbench/quadrature_encoder_counter_test.sv ----
// self-checking bench for the quadrature encoder counter.
// assumes the design package is compiled first; 100 MHz clock.
`timescale 1ns/1ps
module quadrature_encoder_counter_test;
  logic clk, resetn, reg_wr, reg_rd, step_dir_mode, irq;
  logic [6:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ramp_current_position, seed, exp_pos, scale;
  logic enc_a, enc_b, enc_n, move, dir_up, jump, index_lvl;
  logic [15:0] exp_frac;
  logic [10:0] cfg;
  int mismatches, n_compared;

  qec_counter uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_a(enc_a), .enc_b(enc_b),
    .enc_n(enc_n), .step_dir_mode(step_dir_mode),
    .ramp_current_position(ramp_current_position), .irq(irq));
  qec_enc_model enc (.clk(clk), .move(move), .dir_up(dir_up), .jump(jump),
    .index_lvl(index_lvl), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand in the cycle after the strobe
  task automatic rdc(input string name, input logic [6:0] a, input logic [31:0] expv);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(name, reg_rdata, expv);
  endtask

  task automatic setcfg(input logic [10:0] c);
    wr(qec_pkg::ADDR_CONFIG, {21'h0_0000, c});
    cfg = c;
    repeat (4) @(posedge clk);
  endtask

  // expected accumulation, binary 16.16 or decimal ten-thousandths
  task automatic acc(input logic up);
    longint t, d;
    if (cfg[qec_pkg::CFG_DECIMAL]) begin
      t = longint'($signed(exp_pos)) * 10000 + longint'(exp_frac);
      d = longint'($signed(scale[31:16])) * 10000 + longint'(scale[15:0]);
      t = up ? t + d : t - d;
      d = t % 10000;
      t = t / 10000;
      if (d < 0) begin
        d = d + 10000;
        t = t - 1;
      end
      exp_pos = t[31:0];
      exp_frac = d[15:0];
    end else begin
      {exp_pos, exp_frac} = up ? {exp_pos, exp_frac} + {{16{scale[31]}}, scale}
                               : {exp_pos, exp_frac} - {{16{scale[31]}}, scale};
    end
  endtask

  task automatic step(input logic up);
    @(posedge clk);
    move <= 1'b1;
    dir_up <= up;
    @(posedge clk);
    move <= 1'b0;
    repeat (5) @(posedge clk);
    if (!step_dir_mode) acc(up);
  endtask

  task automatic rand_steps(input int n);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      step(seed[0]);
    end
  endtask

  task automatic pulse_n(input logic lvl);
    @(posedge clk);
    index_lvl <= lvl;
    repeat (6) @(posedge clk);
  endtask

  task automatic load_pos(input logic [31:0] p);
    wr(qec_pkg::ADDR_POSITION, p);
    exp_pos = p;
    exp_frac = 16'h0000;
  endtask

  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog
  initial begin
    #500_000;
    mismatches++;
    stop_test;
  end

  // main sequence
  initial begin
    {resetn, reg_wr, reg_rd, step_dir_mode, move, dir_up, jump, index_lvl} = 8'h00;
    reg_addr = 7'h00;
    reg_wdata = 32'h0000_0000;
    ramp_current_position = 32'h0000_0000;
    seed = 32'h0000_2E53;
    cfg = 11'h000;
    scale = qec_pkg::SCALE_RESET;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    wr(qec_pkg::ADDR_CAPTURE, 32'hDEAD_BEEF);
    rdc("capture", qec_pkg::ADDR_CAPTURE, 32'h0000_0000);
    rdc("unmapped", 7'h10, 32'h0000_0000);
    // reset config: level, N, A and B low active; all pins low qualify
    rdc("flags", qec_pkg::ADDR_FLAGS, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    // unity scale counting, then double transitions
    seed = lfsr(seed);
    load_pos(seed);
    rdc("position", qec_pkg::ADDR_POSITION, exp_pos);
    rand_steps(24);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      jump <= 1'b1;
      @(posedge clk);
      jump <= 1'b0;
      repeat (5) @(posedge clk);
    end
    rdc("position", qec_pkg::ADDR_POSITION, exp_pos);
    // frozen in step/dir mode
    step_dir_mode <= 1'b1;
    step(1'b1);
    step(1'b0);
    step_dir_mode <= 1'b0;
    rdc("position", qec_pkg::ADDR_POSITION, exp_pos);
    // random signed binary scale, sign chosen by software
    seed = lfsr(seed);
    scale = seed;
    wr(qec_pkg::ADDR_SCALE, scale);
    rdc("scale", qec_pkg::ADDR_SCALE, 32'h0000_0000);
    rand_steps(16);
    rdc("position", qec_pkg::ADDR_POSITION, exp_pos);
    // decimal scale
    setcfg(11'h400);
    seed = lfsr(seed);
    scale = {seed[31:16], 16'(seed[15:0] % 16'd10000)};
    wr(qec_pkg::ADDR_SCALE, scale);
    load_pos(lfsr(seed));
    rand_steps(16);
    rdc("position", qec_pkg::ADDR_POSITION, exp_pos);
    // index sensitivity for every mode and both polarities
    setcfg(11'h000);
    scale = qec_pkg::SCALE_RESET;
    wr(qec_pkg::ADDR_SCALE, scale);
    for (int i = 0; i < 8; i++) begin
      logic [2:0] m;
      m = i[2:0];
      pulse_n(~m[2]);
      setcfg({3'h0, m[1:0], 3'h1, m[2], 2'h0});
      wr(qec_pkg::ADDR_FLAGS, 32'h0000_0001);
      pulse_n(m[2]);
      rdc("flag active", qec_pkg::ADDR_FLAGS, {31'h0, m[1:0] != 2'h2});
      wr(qec_pkg::ADDR_FLAGS, 32'h0000_0001);
      pulse_n(~m[2]);
      rdc("flag inactive", qec_pkg::ADDR_FLAGS, {31'h0, m[1:0] != 2'h1});
      chk("irq", {31'h0, irq}, {31'h0, m[1:0] != 2'h1});
      wr(qec_pkg::ADDR_FLAGS, 32'h0000_0001);
    end
    // continuous capture with ramp capture and clear
    ramp_current_position <= lfsr(seed);
    setcfg(11'h35C);
    rdc("config", qec_pkg::ADDR_CONFIG, 32'h0000_035C);
    for (int i = 0; i < 2; i++) begin
      rand_steps(3);
      pulse_n(1'b1);
      pulse_n(1'b0);
      rdc("capture", qec_pkg::ADDR_CAPTURE, exp_pos);
      rdc("ramp capture", qec_pkg::ADDR_RAMP_CAPTURE, ramp_current_position);
      exp_pos = 32'h0000_0000;
      exp_frac = 16'h0000;
      rdc("position", qec_pkg::ADDR_POSITION, exp_pos);
    end
    // capture once after the write
    ramp_current_position <= 32'h0000_0000;
    setcfg(11'h06C);
    step(1'b1);
    pulse_n(1'b1);
    pulse_n(1'b0);
    step(1'b1);
    pulse_n(1'b1);
    pulse_n(1'b0);
    rdc("capture", qec_pkg::ADDR_CAPTURE, 32'h0000_0001);
    rdc("position", qec_pkg::ADDR_POSITION, exp_pos);
    // single shot on a held level fires only on the first cycle
    setcfg(11'h02C);
    pulse_n(1'b1);
    pulse_n(1'b0);
    rdc("capture", qec_pkg::ADDR_CAPTURE, exp_pos);
    // a/b levels must match the configured ones
    for (int i = 0; i < 2; i++) begin
      wr(qec_pkg::ADDR_FLAGS, 32'h0000_0003);
      setcfg({7'h05, 2'h1, enc_b, enc_a ^ (i == 0)});
      pulse_n(1'b1);
      pulse_n(1'b0);
      rdc("ab match", qec_pkg::ADDR_FLAGS, {31'h0, i == 1});
    end
    wr(qec_pkg::ADDR_FLAGS, 32'h0000_0001);
    step_dir_mode <= 1'b1;
    pulse_n(1'b1);
    pulse_n(1'b0);
    step_dir_mode <= 1'b0;
    rdc("frozen index", qec_pkg::ADDR_FLAGS, 32'h0000_0000);
    // deviation warning
    wr(qec_pkg::ADDR_SLIP_LIMIT, 32'h0000_0005);
    ramp_current_position <= exp_pos + 32'h0000_0006;
    repeat (3) @(posedge clk);
    wr(qec_pkg::ADDR_FLAGS, 32'h0000_0002);
    rdc("deviation held", qec_pkg::ADDR_FLAGS, 32'h0000_0002);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    ramp_current_position <= exp_pos - 32'h0000_0005;
    repeat (3) @(posedge clk);
    wr(qec_pkg::ADDR_FLAGS, 32'h0000_0002);
    rdc("deviation edge", qec_pkg::ADDR_FLAGS, 32'h0000_0000);
    wr(qec_pkg::ADDR_SLIP_LIMIT, 32'h0000_0000);
    ramp_current_position <= exp_pos + 32'h0000_1000;
    repeat (3) @(posedge clk);
    rdc("deviation off", qec_pkg::ADDR_FLAGS, 32'h0000_0000);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    stop_test;
  end
endmodule // quadrature_encoder_counter_test
